// ==== hw/pnpil_pkg.sv ====
// constants, register map and state type for the plug-and-play local interface
package pnpil_pkg;
    // ------------------------------------------------------------------
    // auto-configuration ports (12-bit isa i/o address)
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_PORT_STD  = 12'h279;
    localparam logic [11:0] ADDR_PORT_ALT  = 12'h259;
    localparam logic [11:0] WDATA_PORT_STD = 12'ha79;
    localparam logic [11:0] WDATA_PORT_ALT = 12'ha59;
    localparam logic [1:0]  RD_PORT_LOW    = 2'h3;   // read port = {rd_port, 2'b11}
    // ------------------------------------------------------------------
    // configuration register indices
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RD_PORT   = 8'h00;
    localparam logic [7:0] REG_CFG_CTRL  = 8'h02;    // config_control
    localparam logic [7:0] REG_WAKE      = 8'h03;
    localparam logic [7:0] REG_CSN       = 8'h06;
    localparam logic [7:0] REG_GPIO_DATA = 8'h20;    // gpio_data
    localparam logic [7:0] REG_GPIO_DIR  = 8'h21;    // gpio_direction
    localparam logic [7:0] REG_ACTIVATE  = 8'h30;    // device_activate
    localparam logic [7:0] REG_MAP_ADDR  = 8'hf0;    // mapped register address
    // ------------------------------------------------------------------
    // command values and key generator
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_BOARD_RESET = 8'h07;
    localparam logic [7:0] CMD_WAIT_KEY    = 8'h02;
    localparam logic [7:0] KEY_SEED        = 8'h6a;
    localparam logic [5:0] KEY_LAST        = 6'h1f;  // 32 key writes
    // ------------------------------------------------------------------
    // timing: board reset pulse after a software reset command
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int BOARD_RST_NS  = 1000;
    localparam int BOARD_RST_CYC = (BOARD_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ------------------------------------------------------------------
    // configuration sequence states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PNPIL_WAIT_KEY,
        PNPIL_SLEEP,
        PNPIL_ISOLATE,
        PNPIL_CONFIG
    } pnpil_state_t;
endpackage

// ==== hw/pnpil_local_if.sv ====
// local-side interface: strobes, address map, gpio, config sequence, board reset
`timescale 1ns/1ps
module pnpil_local_if
    import pnpil_pkg::*;
#(
    parameter int GPIO_W    = 4,
    parameter int LADDR_W   = 7,
    parameter int RST_CYC   = BOARD_RST_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               arst_n,            // isa bus reset, active low
    input  wire logic [11:0]        isa_addr,          // isa address
    input  wire logic [7:0]         isa_data_in,
    output logic      [7:0]         isa_data_out,
    output logic                    isa_data_oe_n,
    input  wire logic               isa_ior_n,
    input  wire logic               isa_iow_n,
    input  wire logic               isa_memr_n,
    input  wire logic               isa_memw_n,
    input  wire logic               alt_port_map_select,
    input  wire logic               io_window0_select_n,
    input  wire logic               io_window1_select_n,
    input  wire logic               mem_window0_select_n,
    output logic                    cs_n,
    output logic                    read_n,
    output logic                    write_n,
    output logic [LADDR_W-1:0]      local_addr,
    input  wire logic               local_ready,
    output logic                    iochrdy_out,
    output logic                    iochrdy_oe_n,
    input  wire logic [GPIO_W-1:0]  gpio_lines_in,
    output logic      [GPIO_W-1:0]  gpio_lines_out,
    output logic      [GPIO_W-1:0]  gpio_lines_oe_n,
    input  wire logic               activate_after_reset_in_n,
    input  wire logic               eeprom_load_done,  // one-cycle pulse from eeprom loader
    input  wire logic               eeprom_irq_a_pol,
    input  wire logic               eeprom_irq_b_pol,
    input  wire logic               irq_in_a,
    input  wire logic               irq_in_b,
    output logic                    irq_out_a,
    output logic                    irq_out_b,
    input  wire logic               dma_req_in_a,
    input  wire logic               dma_req_in_b,
    output logic                    dma_req_out_a,
    output logic                    dma_req_out_b,
    input  wire logic               isa_dack_a_n,
    input  wire logic               isa_dack_b_n,
    output logic                    dma_ack_out_a_n,
    output logic                    dma_ack_out_b_n,
    output logic                    board_reset_n,
    output pnpil_pkg::pnpil_state_t cfg_state
);
    import pnpil_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers: three flops, a change counts when 2nd and 3rd agree
    // ------------------------------------------------------------------
    localparam int SYNC_W = 12 + 8 + 4 + GPIO_W;
    logic [SYNC_W-1:0] sync_raw;
    logic [SYNC_W-1:0] sync_s1;                        // read only by sync_s2
    logic [SYNC_W-1:0] sync_s2;
    logic [SYNC_W-1:0] sync_s3;
    logic [SYNC_W-1:0] sync_filt;                      // settled pin levels
    logic [SYNC_W-1:0] next_sync_filt;
    logic [11:0]       f_addr;
    logic [7:0]        f_data;
    logic              f_iow_n;
    logic              f_ior_n;
    logic              f_act_n;
    logic              f_alt;
    logic [GPIO_W-1:0] f_gpio;
    logic              iow_dly;                        // previous settled iow level

    assign sync_raw = {isa_addr, isa_data_in, isa_iow_n, isa_ior_n, activate_after_reset_in_n,
                       alt_port_map_select, gpio_lines_in};
    assign {f_addr, f_data, f_iow_n, f_ior_n, f_act_n, f_alt, f_gpio} = sync_filt;

    // keep the old settled value while the two late stages disagree
    always_comb begin
        next_sync_filt = (~(sync_s2 ^ sync_s3) & sync_s3) | ((sync_s2 ^ sync_s3) & sync_filt);
    end

    // strobes idle high, so all-ones is a quiet reset value
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync_s1   <= '1;
            sync_s2   <= '1;
            sync_s3   <= '1;
            sync_filt <= '1;
            iow_dly   <= 1'b1;
        end else begin
            sync_s1   <= sync_raw;
            sync_s2   <= sync_s1;
            sync_s3   <= sync_s2;
            sync_filt <= next_sync_filt;
            iow_dly   <= f_iow_n;
        end
    end

    // ------------------------------------------------------------------
    // composite strobes, select, local address and ready
    // ------------------------------------------------------------------
    logic io_any;
    assign io_any  = ~io_window0_select_n | ~io_window1_select_n;
    assign read_n  = ~((io_any & ~isa_ior_n) | (~mem_window0_select_n & ~isa_memr_n));
    assign write_n = ~((io_any & ~isa_iow_n) | (~mem_window0_select_n & ~isa_memw_n));
    assign cs_n    = io_window0_select_n & mem_window0_select_n;

    logic [LADDR_W-1:0] map_addr;                      // mapped register address register
    // io window 0 takes priority when it and the memory window are both selected
    always_comb begin
        if (!io_window0_select_n) begin
            local_addr = isa_addr[LADDR_W-1:0];
        end else if (!mem_window0_select_n) begin
            local_addr = map_addr;
        end else begin
            local_addr = '0;
        end
    end

    // open drain: pulled low while the peripheral is not ready
    assign iochrdy_out  = 1'b0;
    assign iochrdy_oe_n = ~(~cs_n & ~(read_n & write_n) & ~local_ready);

    // ------------------------------------------------------------------
    // configuration registers and sequence
    // ------------------------------------------------------------------
    pnpil_state_t      state;
    pnpil_state_t      next_state;
    logic [7:0]        cfg_index;
    logic [7:0]        next_cfg_index;
    logic [7:0]        key_lfsr;
    logic [7:0]        next_key_lfsr;
    logic [5:0]        key_cnt;
    logic [5:0]        next_key_cnt;
    logic [7:0]        card_select_number;
    logic [7:0]        next_csn;
    logic [7:0]        rd_port;
    logic [7:0]        next_rd_port;
    logic [GPIO_W-1:0] gpio_data;
    logic [GPIO_W-1:0] next_gpio_data;
    logic [GPIO_W-1:0] gpio_dir;
    logic [GPIO_W-1:0] next_gpio_dir;
    logic              activate;
    logic              next_activate;
    logic [LADDR_W-1:0] next_map_addr;
    logic [15:0]       rst_cnt;
    logic [15:0]       next_rst_cnt;
    logic [7:0]        next_rd_data;
    logic              next_rd_oe_n;
    logic              wr_edge;
    logic              addr_hit;
    logic              wdata_hit;
    logic              rd_hit;

    // pad a narrow field into an eight-bit read value
    function automatic logic [7:0] pad8(input logic [7:0] v);
        return v;
    endfunction

    assign wr_edge   = iow_dly & ~f_iow_n;
    assign addr_hit  = wr_edge & (f_addr == (f_alt ? ADDR_PORT_ALT : ADDR_PORT_STD));
    assign wdata_hit = wr_edge & (f_addr == (f_alt ? WDATA_PORT_ALT : WDATA_PORT_STD));
    assign rd_hit    = ~f_ior_n & (f_addr == {2'h0, rd_port, RD_PORT_LOW})
                     & (state == PNPIL_CONFIG || state == PNPIL_ISOLATE);

    always_comb begin
        next_state     = state;
        next_cfg_index = cfg_index;
        next_key_lfsr  = key_lfsr;
        next_key_cnt   = key_cnt;
        next_csn       = card_select_number;
        next_rd_port   = rd_port;
        next_gpio_data = gpio_data;
        next_gpio_dir  = gpio_dir;
        next_activate  = activate;
        next_map_addr  = map_addr;
        next_rst_cnt   = (rst_cnt != '0) ? rst_cnt - 16'h0001 : rst_cnt;
        if (addr_hit && state == PNPIL_WAIT_KEY) begin
            // key writes must follow the lfsr exactly; a miss starts over
            if (f_data == key_lfsr) begin
                next_key_lfsr = {key_lfsr[1] ^ key_lfsr[0], key_lfsr[7:1]};
                next_key_cnt  = key_cnt + 6'h01;
                if (key_cnt == KEY_LAST) begin
                    next_state = PNPIL_SLEEP;
                end
            end else begin
                next_key_lfsr = KEY_SEED;
                next_key_cnt  = '0;
            end
        end else if (addr_hit) begin
            next_cfg_index = f_data;
        end
        if (wdata_hit && state != PNPIL_WAIT_KEY) begin
            unique case (cfg_index)
                REG_CFG_CTRL: begin
                    if (f_data == CMD_BOARD_RESET) begin
                        next_rst_cnt = 16'(RST_CYC);
                    end
                    if (f_data == CMD_WAIT_KEY) begin
                        next_state    = PNPIL_WAIT_KEY;
                        next_key_lfsr = KEY_SEED;
                        next_key_cnt  = '0;
                    end
                end
                REG_WAKE: begin
                    if (f_data == 8'h00 && card_select_number == 8'h00) begin
                        next_state = PNPIL_ISOLATE;
                    end else if (f_data != 8'h00 && f_data == card_select_number) begin
                        next_state = PNPIL_CONFIG;
                    end else begin
                        next_state = PNPIL_SLEEP;
                    end
                end
                REG_RD_PORT: next_rd_port = f_data;
                REG_CSN: begin
                    if (state == PNPIL_ISOLATE || state == PNPIL_CONFIG) begin
                        next_csn   = f_data;
                        next_state = PNPIL_CONFIG;
                    end
                end
                REG_GPIO_DATA: begin
                    if (state == PNPIL_CONFIG) begin
                        // input lines keep their old output value
                        next_gpio_data = (gpio_dir & f_data[GPIO_W-1:0]) | (~gpio_dir & gpio_data);
                    end
                end
                REG_GPIO_DIR: if (state == PNPIL_CONFIG) next_gpio_dir = f_data[GPIO_W-1:0];
                REG_ACTIVATE: if (state == PNPIL_CONFIG) next_activate = f_data[0];
                REG_MAP_ADDR: if (state == PNPIL_CONFIG) next_map_addr = f_data[LADDR_W-1:0];
                default: ;
            endcase
        end
        // strap looked at only on the load pulse; the load wins over a same-cycle clear
        if (eeprom_load_done && !f_act_n) begin
            next_activate = 1'b1;
        end
        // read data: gpio reads the settled pin level, not the latch
        unique case (cfg_index)
            REG_GPIO_DATA: next_rd_data = pad8(8'(f_gpio));
            REG_GPIO_DIR:  next_rd_data = pad8(8'(gpio_dir));
            REG_ACTIVATE:  next_rd_data = pad8(8'(activate));
            REG_CSN:       next_rd_data = card_select_number;
            REG_MAP_ADDR:  next_rd_data = pad8(8'(map_addr));
            default:       next_rd_data = 8'h00;
        endcase
        next_rd_oe_n = ~rd_hit;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state         <= PNPIL_WAIT_KEY;
            cfg_index     <= '0;
            key_lfsr      <= KEY_SEED;
            key_cnt       <= '0;
            card_select_number           <= '0;
            rd_port       <= '0;
            gpio_data     <= '0;
            gpio_dir      <= '0;
            activate      <= 1'b0;
            map_addr      <= '0;
            rst_cnt       <= 16'(RST_CYC);             // bus reset also resets the board
            board_reset_n <= 1'b0;
            isa_data_out  <= '0;
            isa_data_oe_n <= 1'b1;
        end else begin
            state         <= next_state;
            cfg_index     <= next_cfg_index;
            key_lfsr      <= next_key_lfsr;
            key_cnt       <= next_key_cnt;
            card_select_number           <= next_csn;
            rd_port       <= next_rd_port;
            gpio_data     <= next_gpio_data;
            gpio_dir      <= next_gpio_dir;
            activate      <= next_activate;
            map_addr      <= next_map_addr;
            rst_cnt       <= next_rst_cnt;
            board_reset_n <= (next_rst_cnt == '0);
            isa_data_out  <= next_rd_data;
            isa_data_oe_n <= next_rd_oe_n;
        end
    end

    // ------------------------------------------------------------------
    // pin outputs; card functions stay silent until activated
    // ------------------------------------------------------------------
    assign cfg_state       = state;
    assign gpio_lines_out  = gpio_data;
    assign gpio_lines_oe_n = ~gpio_dir;
    assign irq_out_a       = activate & (irq_in_a ^ eeprom_irq_a_pol);
    assign irq_out_b       = activate & (irq_in_b ^ eeprom_irq_b_pol);
    assign dma_req_out_a   = activate & dma_req_in_a;
    assign dma_req_out_b   = activate & dma_req_in_b;
    assign dma_ack_out_a_n = isa_dack_a_n | ~activate;
    assign dma_ack_out_b_n = isa_dack_b_n | ~activate;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_rst_cmd;
        wdata_hit && state != PNPIL_WAIT_KEY && cfg_index == REG_CFG_CTRL && f_data == CMD_BOARD_RESET;
    endsequence
    property p_board_rst;
        @(posedge clk_sys) disable iff (!arst_n) s_rst_cmd |=> !board_reset_n [*8];
    endproperty
    a_board_rst: assert property (p_board_rst) else $error("board reset not held");
    property p_rd_strobe;
        @(posedge clk_sys) disable iff (!arst_n) (io_any && !isa_ior_n) |-> !read_n;
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe missing");
    property p_wr_strobe;
        @(posedge clk_sys) disable iff (!arst_n) (!mem_window0_select_n && !isa_memw_n) |-> !write_n;
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe missing");
    property p_gpio_in_keep;
        @(posedge clk_sys) disable iff (!arst_n) ##1 ((gpio_data ^ $past(gpio_data)) & $past(gpio_dir)) == (gpio_data ^ $past(gpio_data));
    endproperty
    a_gpio_in_keep: assert property (p_gpio_in_keep) else $error("input line latch changed");
    property p_addr_map;
        @(posedge clk_sys) disable iff (!arst_n) !io_window0_select_n |-> local_addr == isa_addr[LADDR_W-1:0];
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("local address wrong");
    property p_act_set;
        @(posedge clk_sys) disable iff (!arst_n) (eeprom_load_done && !f_act_n) |=> activate;
    endproperty
    a_act_set: assert property (p_act_set) else $error("activate not set");
    property p_act_hold;
        @(posedge clk_sys) disable iff (!arst_n) (!eeprom_load_done && !wdata_hit) |=> $stable(activate);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("activate changed");
    sequence s_wake0;
        wdata_hit && state == PNPIL_SLEEP && cfg_index == REG_WAKE && f_data == 8'h00 && card_select_number == 8'h00;
    endsequence
    property p_wake0;
        @(posedge clk_sys) disable iff (!arst_n) s_wake0 |=> state == PNPIL_ISOLATE;
    endproperty
    a_wake0: assert property (p_wake0) else $error("no isolation after wake");
    property p_ready;
        @(posedge clk_sys) disable iff (!arst_n) (!cs_n && !read_n && !local_ready) |-> !iochrdy_oe_n;
    endproperty
    a_ready: assert property (p_ready) else $error("channel ready not negated");
    property p_cs;
        @(posedge clk_sys) disable iff (!arst_n) cs_n |-> (io_window0_select_n && mem_window0_select_n);
    endproperty
    a_cs: assert property (p_cs) else $error("composite select wrong");
endmodule // pnpil_local_if

// ==== sim/pnpil_periph_model.sv ====
// peripheral controller and general purpose pin model on the local side
`timescale 1ns/1ps
module pnpil_periph_model (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       cs_n,
    input  wire logic       read_n,
    input  wire logic       write_n,
    input  wire logic [3:0] wait_cyc,   // cycles the controller needs, 0 = prompt
    input  wire logic [1:0] need_dma,   // {b, a} channels wanting the bus
    input  wire logic [3:0] pin_ext,    // levels the board puts on undriven lines
    input  wire logic [3:0] gpio_out,
    input  wire logic [3:0] gpio_oe_n,
    output logic            local_ready,
    output logic [1:0]      dma_req,
    output logic [3:0]      gpio_pins
);
    logic [3:0] cnt;  // cycles since the composite strobe fell
    logic       busy; // selected read or write in progress
    assign busy = !cs_n && (!read_n || !write_n);
    // ready drops with the strobe and rises once the wait has run out
    assign local_ready = !(busy && cnt < wait_cyc);
    assign dma_req = need_dma;
    // pin level: the device where its enable is low, else the board
    assign gpio_pins = (gpio_out & ~gpio_oe_n) | (pin_ext & gpio_oe_n);
    // saturating count, so a stuck strobe cannot wrap ready low again
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) cnt <= 4'h0;
        else cnt <= busy ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
    end
endmodule // pnpil_periph_model

// ==== sim/pnp_isa_local_interface_bench.sv ====
// self-checking bench for the plug-and-play local interface
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module pnp_isa_local_interface_bench;
    import pnpil_pkg::*;
    localparam int RC = 16; // shortened board reset pulse
    logic clk_sys = 1'b0, arst_n = 1'b0, alt_port_map_select = 1'b0, eeprom_load_done = 1'b0;
    logic isa_ior_n = 1'b1, isa_iow_n = 1'b1, isa_memr_n = 1'b1, isa_memw_n = 1'b1;
    logic io_window0_select_n = 1'b1, io_window1_select_n = 1'b1, mem_window0_select_n = 1'b1;
    logic isa_dack_a_n = 1'b1, isa_dack_b_n = 1'b1, activate_after_reset_in_n = 1'b1;
    logic eeprom_irq_a_pol = 1'b0, eeprom_irq_b_pol = 1'b0, irq_in_a = 1'b0, irq_in_b = 1'b0;
    logic [11:0] isa_addr = 12'h000;
    logic [7:0]  isa_data_in = 8'h00, got, k, isa_data_out;
    logic [3:0]  wait_cyc = 4'h2, pin_ext = 4'h5, gpio_lines_out, gpio_lines_oe_n;
    logic [1:0]  need_dma = 2'h0;
    logic [6:0]  local_addr;
    logic isa_data_oe_n, cs_n, read_n, write_n, iochrdy_out, iochrdy_oe_n, irq_out_a, irq_out_b;
    logic dma_req_out_a, dma_req_out_b, dma_ack_out_a_n, dma_ack_out_b_n, board_reset_n, ex_rd, ex_wr;
    wire local_ready, dma_req_in_a, dma_req_in_b;
    wire [3:0] gpio_lines_in;
    pnpil_state_t cfg_state;
    int errors = 0, compares = 0, i, j;
    always #2.5 clk_sys = ~clk_sys;
    pnpil_periph_model model (.clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n), .read_n(read_n),
        .write_n(write_n), .wait_cyc(wait_cyc), .need_dma(need_dma), .pin_ext(pin_ext),
        .gpio_out(gpio_lines_out), .gpio_oe_n(gpio_lines_oe_n), .local_ready(local_ready),
        .dma_req({dma_req_in_b, dma_req_in_a}), .gpio_pins(gpio_lines_in));
    pnpil_local_if #(.RST_CYC(RC)) dut (.*);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic summarize();
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one isa i/o write; strobe held long enough for the synchroniser
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        isa_addr <= a;
        isa_data_in <= d;
        isa_iow_n <= 1'b0;
        tick(6);
        isa_iow_n <= 1'b1;
        tick(5);
    endtask
    function automatic logic [11:0] aport();
        return alt_port_map_select ? ADDR_PORT_ALT : ADDR_PORT_STD;
    endfunction
    task automatic cfg(input logic [7:0] idx, input logic [7:0] v);
        wr(aport(), idx);
        wr(alt_port_map_select ? WDATA_PORT_ALT : WDATA_PORT_STD, v);
    endtask
    task automatic send_key();
        k = KEY_SEED;
        for (i = 0; i < 32; i++) begin
            wr(aport(), k);
            k = {k[1] ^ k[0], k[7:1]};
        end
    endtask
    // index write, then read at the read port set to 0x80 (isa address 0x203)
    task automatic rd(input logic [7:0] idx);
        wr(aport(), idx);
        @(posedge clk_sys);
        isa_addr <= 12'h203;
        isa_ior_n <= 1'b0;
        for (j = 0; j < 20 && isa_data_oe_n !== 1'b0; j++) @(posedge clk_sys);
        if (j == 20) begin errors++; summarize(); end
        tick(1);
        got = isa_data_out;
        isa_ior_n <= 1'b1;
        tick(8);
    endtask
    task automatic load_pulse();
        @(posedge clk_sys);
        eeprom_load_done <= 1'b1;
        @(posedge clk_sys);
        eeprom_load_done <= 1'b0;
        tick(2);
    endtask
    initial begin
        tick(5);
        arst_n <= 1'b1;
        irq_in_a <= 1'b1;
        need_dma <= 2'h3;
        #1;
        `CHK(cfg_state, PNPIL_WAIT_KEY)
        `CHK({board_reset_n, irq_out_a, dma_req_out_a}, 3'b000)
        tick(RC + 4);
        `CHK(board_reset_n, 1'b1)
        // strap high at load, then strap low without a load: both leave it idle
        load_pulse();
        activate_after_reset_in_n <= 1'b0;
        tick(6);
        `CHK(irq_out_a, 1'b0)
        load_pulse();
        activate_after_reset_in_n <= 1'b1;
        #1 `CHK(irq_out_a, 1'b1)
        // every polarity and acknowledge combination
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {eeprom_irq_b_pol, eeprom_irq_a_pol} <= i[1:0];
            {irq_in_b, irq_in_a} <= {1'b1, i[1]};
            need_dma <= i[1:0];
            {isa_dack_b_n, isa_dack_a_n} <= {i[0], i[1]};
            #1 `CHK({irq_out_a, irq_out_b}, {i[1] ^ i[0], ~i[1]})
            `CHK({dma_req_out_b, dma_req_out_a}, i[1:0])
            `CHK({dma_ack_out_b_n, dma_ack_out_a_n}, {i[0], i[1]})
        end
        // each window select against each isa strobe; controller slow by 2
        for (i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            {mem_window0_select_n, io_window1_select_n, io_window0_select_n} <= ~(3'b001 << (i / 4));
            {isa_memw_n, isa_memr_n, isa_iow_n, isa_ior_n} <= ~(4'b0001 << (i % 4));
            isa_addr <= 12'h3a5;
            #1 ex_rd = !((i < 8 && i % 4 == 0) || i == 10);
            ex_wr = !((i < 8 && i % 4 == 1) || i == 11);
            `CHK({cs_n, read_n, write_n}, {i / 4 == 1, ex_rd, ex_wr})
            `CHK(iochrdy_oe_n, i / 4 == 1 || (ex_rd && ex_wr))
            if (i / 4 == 0) `CHK(local_addr, 7'h25)
            tick(3);
            #1 `CHK({iochrdy_out, iochrdy_oe_n}, 2'b01)
            // one idle edge so the controller sees each cycle start afresh
            @(posedge clk_sys);
            {isa_memw_n, isa_memr_n, isa_iow_n, isa_ior_n} <= 4'hf;
        end
        @(posedge clk_sys);
        {mem_window0_select_n, io_window1_select_n, io_window0_select_n} <= 3'h7;
        {isa_memw_n, isa_memr_n, isa_iow_n, isa_ior_n} <= 4'hf;
        send_key();
        `CHK(cfg_state, PNPIL_SLEEP)
        alt_port_map_select <= 1'b1;
        tick(4);
        cfg(REG_CFG_CTRL, CMD_WAIT_KEY);
        `CHK(cfg_state, PNPIL_WAIT_KEY)
        send_key();
        `CHK(cfg_state, PNPIL_SLEEP)
        cfg(REG_WAKE, 8'h00);
        `CHK(cfg_state, PNPIL_ISOLATE)
        cfg(REG_CSN, 8'h05);
        `CHK(cfg_state, PNPIL_CONFIG)
        cfg(REG_WAKE, 8'h09);
        `CHK(cfg_state, PNPIL_SLEEP)
        cfg(REG_WAKE, 8'h05);
        `CHK(cfg_state, PNPIL_CONFIG)
        cfg(REG_RD_PORT, 8'h80);
        cfg(REG_GPIO_DIR, 8'h03);
        cfg(REG_GPIO_DATA, 8'h0a);
        `CHK({gpio_lines_oe_n, gpio_lines_out}, 8'hc2)
        rd(REG_GPIO_DATA);
        `CHK(got, 8'h06)
        `CHK(isa_data_oe_n, 1'b1)
        rd(REG_CSN);
        `CHK(got, 8'h05)
        cfg(REG_MAP_ADDR, 8'h55);
        @(posedge clk_sys);
        mem_window0_select_n <= 1'b0;
        isa_memr_n <= 1'b0;
        #1 `CHK(local_addr, 7'h55)
        @(posedge clk_sys);
        mem_window0_select_n <= 1'b1;
        isa_memr_n <= 1'b1;
        cfg(REG_CFG_CTRL, CMD_BOARD_RESET);
        `CHK(board_reset_n, 1'b0)
        tick(RC + 4);
        `CHK(board_reset_n, 1'b1)
        // software clear of the activate bit silences the card functions again
        cfg(REG_ACTIVATE, 8'h00);
        `CHK({irq_out_b, irq_out_a, dma_req_out_b, dma_req_out_a}, 4'h0)
        summarize();
    end
endmodule // pnp_isa_local_interface_bench
